/* rtl/rsa_pkg.sv */
// Purpose: Shared constants, slot kinds and frame helpers for the
//          STM-4 regenerator section adaptation block.
// Assumes: One clock cycle carries one byte of the 9 x 1080 byte frame.
// Notes:   One line per rule follows.
package rsa_pkg;

   // -----------------------------------------------------------------
   // Frame geometry.
   // -----------------------------------------------------------------
   localparam logic [3:0] ROW_LAST = 4'h8;  // Nine rows.
   localparam logic [10:0] COL_LAST = 11'h437;  // 1080 columns.
   localparam logic [3:0] OH_ROW_LAST = 4'h2;  // Overhead rows 0..2.
   localparam logic [10:0] OH_COL_LAST = 11'h023;  // Overhead cols 0..35.
   localparam logic [3:0] ORDER_ROW = 4'h1;  // Row holding E1 and F1.
   localparam logic [10:0] E1_COL = 11'h00c;  // E1 column.
   localparam logic [10:0] F1_COL = 11'h018;  // F1 column.
   localparam logic [3:0] DCC_ROW = 4'h2;  // Row holding D1..D3.
   localparam logic [10:0] D1_COL = 11'h000;  // D1 column.
   localparam logic [10:0] D2_COL = 11'h00c;  // D2 column.
   localparam logic [10:0] D3_COL = 11'h018;  // D3 column.
   localparam int FRAME_BYTES = 9720;  // Bytes in one frame.
   localparam int BIT_DIV = FRAME_BYTES / 8;  // Byte clocks per 64 kHz bit.
   localparam logic [7:0] ALL_ONES = 8'hff;  // Replacement pattern.
   localparam logic [7:0] IDLE_BYTE = 8'h00;  // Unused overhead content.

   // -----------------------------------------------------------------
   // Timing and store sizing.
   // -----------------------------------------------------------------
   localparam int CLK_MHZ = 20;  // Clock rate in MHz.
   localparam int SRC_AIS_US = 250;  // Longest source replacement time.
   localparam int SRC_AIS_CYC = SRC_AIS_US * CLK_MHZ;  // Cycles, round down.
   localparam int TRIB_AIS_US = 1000;  // Longest sink replacement time.
   localparam int TRIB_AIS_CYC = TRIB_AIS_US * CLK_MHZ;  // Cycles, round down.
   localparam int STORE_AW = 2;  // Four octets cover 18 us many times.
   localparam logic [2:0] FILL_LOW = 3'h1;  // Underflow margin.
   localparam logic [2:0] FILL_HIGH = 3'h3;  // Overflow margin.

   // Kind of byte at a frame position.
   typedef enum logic [2:0] {SL_MS, SL_DCC, SL_E1, SL_F1, SL_OTHER} rsa_slot_t;

   // Classifies one frame position.
   function automatic rsa_slot_t rsa_slot(input logic [3:0] row, input logic [10:0] col);
      if (row <= OH_ROW_LAST && col <= OH_COL_LAST) begin
         if (row == ORDER_ROW && col == E1_COL) return SL_E1;
         if (row == ORDER_ROW && col == F1_COL) return SL_F1;
         if (row == DCC_ROW && (col == D1_COL || col == D2_COL || col == D3_COL)) return SL_DCC;
         return SL_OTHER;
      end
      return SL_MS;
   endfunction

   // Advances a {row, col} position by one byte, wrapping at frame end.
   function automatic logic [14:0] rsa_adv(input logic [3:0] row, input logic [10:0] col);
      if (col != COL_LAST) return {row, col + 11'h001};
      if (row != ROW_LAST) return {row + 4'h1, 11'h000};
      return 15'h0000;
   endfunction

endpackage

/* rtl/rsa_store.sv */
// Purpose: Small octet store for the tributary elastic buffer.
// Assumes: Writes and reads share one clock.
// Notes:   Read data comes out of a register one cycle after the address.
`timescale 1ns/1ns
`default_nettype none
module rsa_store #(
   parameter int W = 8,
   parameter int AW = 2
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [W-1:0] wdata_i,
   input wire logic [AW-1:0] raddr_i,
   output logic [W-1:0] rdata_o
);
   // -----------------------------------------------------------------
   // State.
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [(1<<AW)-1:0][W-1:0] mem;  // Octet cells.
      logic [W-1:0] rdata;  // Registered read data.
   } rss_state_t;
   rss_state_t st_ff, nxt_st;

   // Writes one cell when we_i is high and reads one cell each cycle.
   always_comb begin
      nxt_st = st_ff;
      if (we_i) nxt_st.mem[waddr_i] = wdata_i;
      nxt_st.rdata = st_ff.mem[raddr_i];
   end

   // Registers the state.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) st_ff <= '0;
      else st_ff <= nxt_st;
   end

   assign rdata_o = st_ff.rdata;
endmodule // rsa_store
`default_nettype wire

/* rtl/rsa_buf2.sv */
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock.
// Notes:   Input ready is registered, so a full buffer stalls the source.
`timescale 1ns/1ns
`default_nettype none
module rsa_buf2 #(
   parameter int W = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   // -----------------------------------------------------------------
   // State.
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [1:0][W-1:0] word;  // Entry 0 is the head.
      logic [1:0] count;  // Words held.
      logic ready;  // Room for a word next cycle.
   } rsb_state_t;
   rsb_state_t st_ff, nxt_st;

   // Pops the head and pushes at the tail in the same cycle if asked.
   always_comb begin
      logic push;
      logic pop;
      logic [1:0] cnt;
      nxt_st = st_ff;
      push = in_valid_i && st_ff.ready;
      pop = out_ready_i && (st_ff.count != 2'h0);
      cnt = st_ff.count;
      if (pop) begin
         nxt_st.word[0] = st_ff.word[1];
         cnt = cnt - 2'h1;
      end
      if (push) begin
         nxt_st.word[cnt[0]] = in_data_i;
         cnt = cnt + 2'h1;
      end
      nxt_st.count = cnt;
      nxt_st.ready = (cnt != 2'h2);
   end

   // Registers the state.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) st_ff <= '0;
      else st_ff <= nxt_st;
   end

   assign in_ready_o = st_ff.ready;
   assign out_valid_o = (st_ff.count != 2'h0);
   assign out_data_o = st_ff.word[0];
endmodule // rsa_buf2
`default_nettype wire

/* rtl/rsa_top.sv */
// Purpose: Regenerator section adaptation, both directions, for an
//          STM-4 frame: payload, data channel and one 64 kbit/s channel.
// Assumes: CLOCK_I is the frame byte clock; one byte per cycle.
// Notes:   The tributary clock and data are pins and are synchronised.
`timescale 1ns/1ns
`default_nettype none
module rsa_top
   import rsa_pkg::*;
#(
   parameter bit SEL_F1 = 1'b0  // Channel byte: 0 selects E1, 1 selects F1.
) (
   input wire logic CLOCK_I,
   input wire logic RST_I,
   // Source side: frame timing, payload and its fail.
   input wire logic LINE_TIMING_FRAME_START_I,
   input wire logic [7:0] MUX_SECTION_DATA_I,
   input wire logic MUX_SECTION_FAIL_I = 1'b0,
   // Channel bytes for the D bytes.
   input wire logic [7:0] COMM_CHANNEL_DATA_I,
   input wire logic COMM_CHANNEL_VALID_I,
   output logic COMM_CHANNEL_READY_O,
   output logic COMM_CHANNEL_CLOCK_O,
   // Tributary pins from another clock.
   input wire logic TRIBUTARY_64K_DATA_I,
   input wire logic TRIBUTARY_64K_CLOCK_I,
   input wire logic TRIBUTARY_64K_OCTET_I,
   // Access point, both directions.
   output logic [7:0] REGEN_ACCESS_DATA_O,
   output logic REGEN_ACCESS_FRAME_START_O,
   input wire logic [7:0] REGEN_ACCESS_DATA_I,
   input wire logic REGEN_ACCESS_FRAME_START_I,
   input wire logic TRAIL_FAIL_IN_I,
   // Sink side outputs.
   output logic [7:0] MUX_SECTION_DATA_O,
   output logic MUX_SECTION_VALID_O,
   output logic MUX_SECTION_FRAME_START_O,
   output logic MUX_SECTION_FAIL_O,
   output logic [7:0] COMM_CHANNEL_DATA_O,
   output logic COMM_CHANNEL_VALID_O,
   output logic COMM_CHANNEL_FAIL_O,
   output logic TRIBUTARY_64K_DATA_O,
   output logic TRIBUTARY_64K_CLOCK_O,
   output logic TRIBUTARY_64K_FAIL_O
);
   // -----------------------------------------------------------------
   // State of the block.
   // -----------------------------------------------------------------
   // Channel byte choice and the 64 kHz divider points.
   localparam rsa_slot_t CH_SLOT = SEL_F1 ? SL_F1 : SL_E1;  // Chosen byte.
   localparam logic [10:0] DIV_LAST = 11'(BIT_DIV - 1);  // Divider wrap.
   localparam logic [10:0] DIV_HALF = 11'(BIT_DIV / 2);  // Clock high half.

   typedef struct packed {
      // Frame positions.
      logic [3:0] src_row;  // Source position of the next byte.
      logic [10:0] src_col;
      logic [3:0] snk_row;  // Sink position of the next byte.
      logic [10:0] snk_col;
      // Source line and channel.
      logic [7:0] ao_data;  // Access output byte.
      logic ao_fs;  // Access output frame start.
      logic cc_clk;  // Channel byte taken.
      // Tributary input and slip buffer.
      logic [2:0] tr_sync1;  // First stage: clock, data, octet.
      logic [2:0] tr_sync2;  // Second stage.
      logic tr_clk_d;  // Previous synced tributary clock.
      logic [7:0] tr_sh;  // Incoming tributary bits.
      logic [2:0] tr_bits;  // Bits gathered in the octet.
      logic [2:0] wr_ptr;  // Store write pointer.
      logic [2:0] rd_ptr;  // Store read pointer.
      logic [7:0] last_oct;  // Octet last sent.
      // Sink pass-through outputs.
      logic [7:0] ms_data;  // Sink payload output.
      logic ms_val;
      logic ms_fs;
      logic ms_fail;
      logic [7:0] cc_data;  // Sink channel output.
      logic cc_val;
      logic cc_fail;
      // Sink tributary smoothing.
      logic [7:0] k_latch;  // Latched received octet.
      logic [7:0] k_sh;  // Bits being shifted out.
      logic [10:0] k_div;  // 64 kHz divider.
      logic [2:0] k_bit;  // Bit within the octet.
      logic k_dat;
      logic k_clk;
      logic k_fail;
   } rsa_state_t;
   rsa_state_t st_ff, nxt_st;

   // -----------------------------------------------------------------
   // Helpers.
   // -----------------------------------------------------------------
   logic [3:0] src_row;  // Source position of the current byte.
   logic [10:0] src_col;
   logic [3:0] snk_row;  // Sink position of the current byte.
   logic [10:0] snk_col;
   rsa_slot_t src_slot;  // Kind of the current source byte.
   rsa_slot_t snk_slot;  // Kind of the current sink byte.
   logic [2:0] fill;  // Octets held in the elastic store.
   logic [7:0] st_rdata;  // Store read data.
   logic cc_take;  // Channel byte consumed this cycle.
   logic cc_valid;  // Buffer holds a channel byte.
   logic [7:0] cc_bdata;  // Buffer head byte.
   logic tr_edge;  // Rising edge of the tributary clock.
   logic tr_write;  // A full octet goes into the store.
   logic k_tick;  // One 64 kHz bit period has ended.

   // Positions restart on frame start, otherwise run on.
   always_comb begin
      src_row = LINE_TIMING_FRAME_START_I ? 4'h0 : st_ff.src_row;
      src_col = LINE_TIMING_FRAME_START_I ? 11'h000 : st_ff.src_col;
      snk_row = REGEN_ACCESS_FRAME_START_I ? 4'h0 : st_ff.snk_row;
      snk_col = REGEN_ACCESS_FRAME_START_I ? 11'h000 : st_ff.snk_col;
      src_slot = rsa_slot(src_row, src_col);
      snk_slot = rsa_slot(snk_row, snk_col);
   end

   // One spare pointer bit tells a full store from an empty one.
   assign fill = st_ff.wr_ptr - st_ff.rd_ptr;
   assign cc_take = (src_slot == SL_DCC) && cc_valid;
   assign tr_edge = st_ff.tr_sync2[2] && !st_ff.tr_clk_d;
   // An octet is whole on its eighth edge; a marker there starts anew.
   assign tr_write = tr_edge && (st_ff.tr_bits == 3'h7) && !st_ff.tr_sync2[0];
   assign k_tick = (st_ff.k_div == DIV_LAST);

   // -----------------------------------------------------------------
   // Channel buffer and elastic store.
   // -----------------------------------------------------------------
   // Channel bytes wait here until the next D byte comes round.
   rsa_buf2 #(.W(8)) u_cc_buf (
      .clk_i(CLOCK_I),
      .rst_i(RST_I),
      .in_valid_i(COMM_CHANNEL_VALID_I),
      .in_ready_o(COMM_CHANNEL_READY_O),
      .in_data_i(COMM_CHANNEL_DATA_I),
      .out_valid_o(cc_valid),
      .out_ready_i(src_slot == SL_DCC),
      .out_data_o(cc_bdata)
   );

   // Four-octet slip buffer between tributary and frame timing.
   rsa_store #(.W(8), .AW(STORE_AW)) u_store (
      .clk_i(CLOCK_I),
      .rst_i(RST_I),
      .we_i(tr_write),
      .waddr_i(st_ff.wr_ptr[1:0]),
      .wdata_i({st_ff.tr_sh[6:0], st_ff.tr_sync2[1]}),
      .raddr_i(st_ff.rd_ptr[1:0]),
      .rdata_o(st_rdata)
   );

   // -----------------------------------------------------------------
   // Next state.
   // -----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      {nxt_st.src_row, nxt_st.src_col} = rsa_adv(src_row, src_col);
      {nxt_st.snk_row, nxt_st.snk_col} = rsa_adv(snk_row, snk_col);

      // Source: pick the byte for the current position.
      nxt_st.ao_fs = LINE_TIMING_FRAME_START_I;
      nxt_st.cc_clk = cc_take;
      case (src_slot)
         SL_MS: nxt_st.ao_data = MUX_SECTION_DATA_I;
         SL_DCC: nxt_st.ao_data = cc_valid ? cc_bdata : ALL_ONES;
         default: nxt_st.ao_data = IDLE_BYTE;
      endcase
      if (src_slot == CH_SLOT) begin
         // Justification is decided from the store fill.
         if (fill <= FILL_LOW) begin
            // Near empty: hold the pointer and send the last octet again.
            nxt_st.ao_data = st_ff.last_oct;
         end else if (fill >= FILL_HIGH) begin
            // Near full: send one octet and drop the next one whole.
            nxt_st.ao_data = st_rdata;
            nxt_st.last_oct = st_rdata;
            nxt_st.rd_ptr = st_ff.rd_ptr + 3'h2;
         end else begin
            // Normal read: one octet per frame.
            nxt_st.ao_data = st_rdata;
            nxt_st.last_oct = st_rdata;
            nxt_st.rd_ptr = st_ff.rd_ptr + 3'h1;
         end
      end
      // A failed server replaces every byte at the same byte rate.
      if (MUX_SECTION_FAIL_I) nxt_st.ao_data = ALL_ONES;

      // Tributary input: sync pins, gather bits, write whole octets.
      nxt_st.tr_sync1 = {TRIBUTARY_64K_CLOCK_I, TRIBUTARY_64K_DATA_I, TRIBUTARY_64K_OCTET_I};
      nxt_st.tr_sync2 = st_ff.tr_sync1;
      nxt_st.tr_clk_d = st_ff.tr_sync2[2];
      // A marker bit restarts the octet, so a cut octet is lost whole.
      if (tr_edge) begin
         nxt_st.tr_sh = {st_ff.tr_sh[6:0], st_ff.tr_sync2[1]};
         nxt_st.tr_bits = st_ff.tr_sync2[0] ? 3'h1 : st_ff.tr_bits + 3'h1;
         if (st_ff.tr_sync2[0]) nxt_st.tr_sh = {7'h00, st_ff.tr_sync2[1]};
      end
      if (tr_write) nxt_st.wr_ptr = st_ff.wr_ptr + 3'h1;

      // Sink: payload and data channel pass through with the fail copy.
      nxt_st.ms_data = REGEN_ACCESS_DATA_I;
      // Valid is low on overhead bytes; data passes either way.
      nxt_st.ms_val = (snk_slot == SL_MS);
      nxt_st.ms_fs = REGEN_ACCESS_FRAME_START_I;
      nxt_st.ms_fail = TRAIL_FAIL_IN_I;
      nxt_st.cc_data = REGEN_ACCESS_DATA_I;
      nxt_st.cc_val = (snk_slot == SL_DCC);
      nxt_st.cc_fail = TRAIL_FAIL_IN_I;

      // Sink tributary: latch the octet, shift it out at 64 kHz.
      if (snk_slot == CH_SLOT) nxt_st.k_latch = REGEN_ACCESS_DATA_I;
      // The divider runs on through a fail so the bit rate holds.
      nxt_st.k_div = k_tick ? 11'h000 : st_ff.k_div + 11'h001;
      nxt_st.k_clk = (st_ff.k_div < DIV_HALF);
      nxt_st.k_fail = TRAIL_FAIL_IN_I;
      // After the eighth bit the shifter reloads from the latch.
      if (k_tick) begin
         nxt_st.k_bit = st_ff.k_bit + 3'h1;
         nxt_st.k_sh = (st_ff.k_bit == 3'h7) ? st_ff.k_latch : {st_ff.k_sh[6:0], 1'b0};
         nxt_st.k_dat = st_ff.k_fail ? 1'b1 : nxt_st.k_sh[7];
      end
   end

   // -----------------------------------------------------------------
   // State register.
   // -----------------------------------------------------------------
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         // Every counter and output starts from zero.
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // -----------------------------------------------------------------
   // Outputs.
   // -----------------------------------------------------------------
   // Source line and channel outputs.
   assign REGEN_ACCESS_DATA_O = st_ff.ao_data;
   assign REGEN_ACCESS_FRAME_START_O = st_ff.ao_fs;
   assign COMM_CHANNEL_CLOCK_O = st_ff.cc_clk;

   // Sink pass-through outputs.
   assign MUX_SECTION_DATA_O = st_ff.ms_data;
   assign MUX_SECTION_VALID_O = st_ff.ms_val;
   assign MUX_SECTION_FRAME_START_O = st_ff.ms_fs;
   assign MUX_SECTION_FAIL_O = st_ff.ms_fail;
   assign COMM_CHANNEL_DATA_O = st_ff.cc_data;
   assign COMM_CHANNEL_VALID_O = st_ff.cc_val;
   assign COMM_CHANNEL_FAIL_O = st_ff.cc_fail;

   // Smoothed tributary outputs.
   assign TRIBUTARY_64K_DATA_O = st_ff.k_dat;
   assign TRIBUTARY_64K_CLOCK_O = st_ff.k_clk;
   assign TRIBUTARY_64K_FAIL_O = st_ff.k_fail;

   // -----------------------------------------------------------------
   // Checks.
   // -----------------------------------------------------------------
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (RST_I);

   // A failed server turns the next access byte to all ones.
   src_fail_ones_a: assert property (MUX_SECTION_FAIL_I |=> REGEN_ACCESS_DATA_O == ALL_ONES)
      else $error("source fail did not force all ones");

   // Payload positions carry the section byte of the same cycle.
   src_payload_a: assert property (!MUX_SECTION_FAIL_I && src_slot == SL_MS
      |=> REGEN_ACCESS_DATA_O == $past(MUX_SECTION_DATA_I))
      else $error("payload byte not placed");

   // Spare overhead bytes are sent as the idle pattern.
   src_oh_idle_a: assert property (!MUX_SECTION_FAIL_I && src_slot == SL_OTHER
      |=> REGEN_ACCESS_DATA_O == IDLE_BYTE)
      else $error("overhead byte not idle");

   // An empty channel buffer leaves the D byte all ones.
   dcc_idle_a: assert property (!MUX_SECTION_FAIL_I && src_slot == SL_DCC && !cc_valid
      |=> REGEN_ACCESS_DATA_O == ALL_ONES)
      else $error("empty channel byte not all ones");

   // Frame start puts the next source byte at column one.
   src_frame_a: assert property (LINE_TIMING_FRAME_START_I
      |=> st_ff.src_row == 4'h0 && st_ff.src_col == 11'h001)
      else $error("frame start did not restart the count");

   // Sink fail reaches both pass-through outputs one cycle on.
   snk_fail_copy_a: assert property (TRAIL_FAIL_IN_I ##1 TRAIL_FAIL_IN_I
      |-> MUX_SECTION_FAIL_O && COMM_CHANNEL_FAIL_O)
      else $error("sink fail not copied");

   // Payload valid is low at column 0 of row 0 and high again at column 36.
   snk_payload_a: assert property (REGEN_ACCESS_FRAME_START_I
      |=> MUX_SECTION_FRAME_START_O && !MUX_SECTION_VALID_O ##36 MUX_SECTION_VALID_O)
      else $error("payload valid misplaced");

   // The channel clock pulses only for a D byte.
   cc_clock_a: assert property (COMM_CHANNEL_CLOCK_O |-> $past(src_slot) == SL_DCC)
      else $error("channel byte taken outside D bytes");

   // The slip buffer never holds more octets than it has cells.
   store_fill_a: assert property (fill <= 3'h4)
      else $error("elastic store overrun");

   // A failed trail sends a one at every bit tick.
   trib_ones_a: assert property (st_ff.k_fail && k_tick |=> TRIBUTARY_64K_DATA_O)
      else $error("tributary replacement missing");

   // The bit divider stays inside its period.
   div_range_a: assert property (st_ff.k_div <= DIV_LAST)
      else $error("bit divider out of range");

   // Near empty, the read pointer holds still.
   cancel_hold_a: assert property (!MUX_SECTION_FAIL_I && src_slot == CH_SLOT
      && fill <= FILL_LOW |=> $stable(st_ff.rd_ptr))
      else $error("read not cancelled");

   // Near full, one whole octet is stepped over.
   skip_read_a: assert property (src_slot == CH_SLOT && fill >= FILL_HIGH
      |=> st_ff.rd_ptr == $past(st_ff.rd_ptr) + 3'h2)
      else $error("octet not skipped");

   // The chosen sink byte is latched for the smoother.
   snk_latch_a: assert property (snk_slot == CH_SLOT
      |=> st_ff.k_latch == $past(REGEN_ACCESS_DATA_I))
      else $error("received octet not latched");

   // Main scenarios: fail, both slip kinds, channel use, sink fail.
   fail_seen_c: cover property ($rose(MUX_SECTION_FAIL_I));
   cancel_seen_c: cover property (src_slot == CH_SLOT && fill <= FILL_LOW);
   slip_seen_c: cover property (src_slot == CH_SLOT && fill >= FILL_HIGH);
   cc_seen_c: cover property (cc_take);
   trib_fail_c: cover property ($rose(TRAIL_FAIL_IN_I));
endmodule // rsa_top
`default_nettype wire

/* test/rsa_trib_model.sv */
// Purpose: Tributary 64 kbit/s source model feeding the slip buffer.
// Assumes: Free-running bit clock, MSB first, marker on the first bit.
// Notes:   Octet n carries {n, ~n} so any partial-octet slip shows up.
`timescale 1ns/1ns
`default_nettype none
module rsa_trib_model (
   input wire logic fast_i,
   output logic clk_o,
   output logic data_o,
   output logic octet_o
);
   logic [3:0] n = 4'h1;  // Octet sequence number.
   integer b;  // Bit index inside the octet.
   // ---------------------------------------------------------------
   // Octet stream; the bit time follows the fast select.
   // ---------------------------------------------------------------
   initial begin
      clk_o = 1'b0;
      data_o = 1'b0;
      octet_o = 1'b0;
      forever begin
         for (b = 7; b >= 0; b--) begin
            data_o = (b > 3) ? n[b-4] : ~n[b];
            octet_o = (b == 7);
            #(fast_i ? 20000 : 40000);
            clk_o = 1'b1;
            #(fast_i ? 20000 : 40000);
            clk_o = 1'b0;
         end
         n = n + 4'h1;
      end
   end
endmodule // rsa_trib_model
`default_nettype wire

/* test/rsa_top_test.sv */
// Purpose: Self-checking bench for the regenerator section adaptation.
// Assumes: E1 carries the tributary; the sink is fed random frames.
// Notes:   Expectations come from a bench-side slot map of the frame.
`timescale 1ns/1ns
`default_nettype none
module rsa_top_test
   import rsa_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, fs = 1'b0, mfail = 1'b0, cvalid = 1'b0;
   logic tfail = 1'b0, fast = 1'b1, pend = 1'b0, pfail, ptf, tck_q = 1'b0, seen_e1 = 1'b0;
   logic [7:0] mdata = 8'h00, cdata = 8'h00, sdata = 8'h00, pdat, psdat, pbyte, win = 8'h00;
   logic [7:0] adata, mout, cout;
   logic [3:0] lastn;
   logic cready, cclk, tclk, tdat, toct, afs, mval, mfs, mfl, cval, cfl, tbit, tck, tfl;
   logic [7:0] q[$];  // Channel bytes accepted but not yet sent.
   integer errors = 0, comparisons = 0, seed = 63, pos = -1, ppos = -1, frame = -1;
   integer cyc = 0, nb = 0, g = 0, f = 0;

   always #25 clk = ~clk;  // 20 MHz byte clock.

   rsa_top rsa_top_inst (.CLOCK_I(clk), .RST_I(rst), .LINE_TIMING_FRAME_START_I(fs),
      .MUX_SECTION_DATA_I(mdata), .MUX_SECTION_FAIL_I(mfail), .COMM_CHANNEL_DATA_I(cdata),
      .COMM_CHANNEL_VALID_I(cvalid), .COMM_CHANNEL_READY_O(cready),
      .COMM_CHANNEL_CLOCK_O(cclk), .TRIBUTARY_64K_DATA_I(tdat),
      .TRIBUTARY_64K_CLOCK_I(tclk), .TRIBUTARY_64K_OCTET_I(toct),
      .REGEN_ACCESS_DATA_O(adata), .REGEN_ACCESS_FRAME_START_O(afs),
      .REGEN_ACCESS_DATA_I(sdata), .REGEN_ACCESS_FRAME_START_I(fs), .TRAIL_FAIL_IN_I(tfail),
      .MUX_SECTION_DATA_O(mout), .MUX_SECTION_VALID_O(mval), .MUX_SECTION_FRAME_START_O(mfs),
      .MUX_SECTION_FAIL_O(mfl), .COMM_CHANNEL_DATA_O(cout), .COMM_CHANNEL_VALID_O(cval),
      .COMM_CHANNEL_FAIL_O(cfl), .TRIBUTARY_64K_DATA_O(tbit), .TRIBUTARY_64K_CLOCK_O(tck),
      .TRIBUTARY_64K_FAIL_O(tfl));

   rsa_trib_model rsa_trib_model_inst (.fast_i(fast), .clk_o(tclk), .data_o(tdat),
      .octet_o(toct));

   // Kind of byte: 0 payload, 1 channel D1-D3, 2 E1, 3 other overhead.
   function automatic int slot(input int p);
      int r = p / 1080;
      int c = p % 1080;
      if (r > 2 || c > 35) return 0;
      if (r == 2 && c % 12 == 0 && c <= 24) return 1;
      if (r == 1 && c == 12) return 2;
      return 3;
   endfunction

   // True when w is some rotation of v.
   function automatic logic is_rot(input logic [7:0] w, input logic [7:0] v);
      for (int i = 0; i < 8; i++) if (8'({v, v} >> i) === w) return 1'b1;
      return 1'b0;
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic end_of_test;
      if (errors == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // One byte: check the edge just passed, then drive the next byte.
   // ---------------------------------------------------------------
   task automatic step;
      int s = slot(ppos);
      logic [3:0] d;
      if (ppos >= 0) begin
         check(cclk, s == 1 && q.size() > 0, "chan clock");
         if (pfail && s == 1 && q.size() > 0) void'(q.pop_front());
         if (pfail) check(adata, ALL_ONES, "fail ones");
         else if (s == 0) check(adata, pdat, "payload");
         else if (s == 1) check(adata, q.size() > 0 ? q.pop_front() : ALL_ONES, "chan");
         else if (s == 2 && (adata !== 8'h00 || seen_e1)) begin
            check({4'h0, adata[7:4]}, {4'h0, ~adata[3:0]}, "octet");
            d = adata[7:4] - lastn;
            if (seen_e1) check({7'h0, d > 4'h2}, 16'h0000, "slip step");
            seen_e1 = 1'b1;
            lastn = adata[7:4];
         end else if (s == 3) check(adata, IDLE_BYTE, "overhead");
         check(afs, ppos == 0, "frame start");
         check(mval, s == 0, "ms valid");
         if (s == 0) check(mout, psdat, "ms data");
         check(mfs, ppos == 0, "ms frame");
         check(mfl, ptf, "ms fail");
         check(cval, s == 1, "dcc valid");
         if (s == 1) check(cout, psdat, "dcc data");
         check(cfl, ptf, "dcc fail");
         check(tfl, ptf, "trib fail");
      end
      cyc++;
      if (tck_q && !tck) begin
         if (nb > 0) check(16'(cyc), 16'(BIT_DIV), "bit period");
         cyc = 0;
         nb++;
         win = {win[6:0], tbit};
         g = tfail ? 0 : g + 1;
         f = tfail ? f + 1 : 0;
         if (f >= 3) check(tbit, 1'b1, "trib ones");
         if (g >= 17) check(is_rot(win, 8'ha5), 1'b1, "trib octet");
      end
      tck_q = tck;
      if (pend) q.push_back(pbyte);
      check(cready, q.size() < 2, "chan ready");
      pos = (pos == FRAME_BYTES - 1) ? 0 : pos + 1;
      if (pos == 0) frame++;
      fs = (pos == 0);
      mdata = 8'($random(seed));
      sdata = (slot(pos) == 2) ? 8'ha5 : 8'($random(seed));
      mfail = (frame == 1 && pos >= 200 && pos < 1000);
      tfail = (frame == 6);
      fast = (frame < 5);
      cvalid = (frame != 2) && ($random(seed) % 2 != 0);
      cdata = 8'($random(seed));
      pend = cvalid && cready;
      pbyte = cdata;
      ppos = pos;
      pdat = mdata;
      pfail = mfail;
      psdat = sdata;
      ptf = tfail;
   endtask

   // ---------------------------------------------------------------
   // Main sequence: reset, then nine frames of mixed traffic.
   // ---------------------------------------------------------------
   initial begin
      repeat (16) @(negedge clk) check(adata, 8'h00, "reset out");
      rst = 1'b0;
      while (frame < 9) @(negedge clk) step();
      end_of_test();
   end
endmodule // rsa_top_test
`default_nettype wire
